// [cfg_regs_pkg.sv]
// Constants, field layouts and state type of the radio configuration bank.
// Assumes one clock domain and an 8-bit register access port.
package cfg_regs_pkg;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_CHAN_A    = 5'h00;
    localparam logic [4:0] IDX_CHAN_B    = 5'h01;
    localparam logic [4:0] IDX_CHAN_C    = 5'h02;
    localparam logic [4:0] IDX_TX_A      = 5'h03;
    localparam logic [4:0] IDX_USER_BASE = 5'h04;
    localparam logic [4:0] IDX_USER_LAST = 5'h0B;
    localparam logic [4:0] IDX_TX_B      = 5'h0C;
    localparam logic [4:0] IDX_SEC_B     = 5'h0D;
    localparam logic [4:0] IDX_RUN       = 5'h0E;
    localparam logic [4:0] IDX_ACTIVE    = 5'h0F;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CHAN_A = 8'h25;
    localparam logic [7:0] RST_CHAN_B = 8'h26;
    localparam logic [7:0] RST_CHAN_C = 8'h27;
    localparam logic [7:0] RST_TX_A   = 8'h00;
    localparam logic [7:0] RST_USER   = 8'h00;
    localparam logic [7:0] RST_TX_B   = 8'h20;
    localparam logic [7:0] RST_SEC_B  = 8'h20;
    localparam logic [7:0] RST_RUN    = 8'h00;
    localparam logic [7:0] SUPPRESS_CODE = 8'hFF;
    localparam logic [7:0] CHAN_MASK     = 8'h7F;
    localparam int CUSTOM_ENCODING_BIT = 6;
    localparam int CUSTOM_SEQ_BIT      = 0;
    localparam int PAIR_DISABLE_BIT    = 4;
    localparam logic [4:0] CHANNEL_BASE = 5'h0B;   // code 0 is channel 11

    // Learn-button channel stepping modes
    localparam logic [1:0] STEP_NONE    = 2'h0;
    localparam logic [1:0] STEP_PRIMARY = 2'h1;
    localparam logic [1:0] STEP_ALL     = 2'h2;
    // Key wrap modes and key choices
    localparam logic [1:0] WRAP_DEFAULT = 2'h0;
    localparam logic [1:0] WRAP_DEF_IC  = 2'h1;
    localparam logic [1:0] WRAP_IC      = 2'h2;
    localparam logic [1:0] KEY_FIRST    = 2'h0;
    localparam logic [1:0] KEY_SECOND   = 2'h1;

    // Primary channel codes (channels 11, 15, 20, 25)
    localparam logic [3:0] PRIM_0 = 4'h0;
    localparam logic [3:0] PRIM_1 = 4'h4;
    localparam logic [3:0] PRIM_2 = 4'h9;
    localparam logic [3:0] PRIM_3 = 4'hE;

    // ------------------------------------------------------------------
    // Module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]      chan_a;
        logic [7:0]      chan_b;
        logic [7:0]      chan_c;
        logic [7:0]      tx_a;
        logic [7:0][7:0] user;
        logic [7:0]      tx_b;
        logic [7:0]      sec_b;
        logic [7:0]      run;
        logic [3:0]      active_code;
        logic [1:0]      learn_sync;
        logic [1:0]      harv_sync;
        logic            harv_prev;
        logic [7:0]      rdata;
        logic            tel_valid;
        logic            tel_supp;
        logic [7:0]      tel_status;
        logic            pair_req;
    } bank_state_t;

    localparam bank_state_t RESET_STATE = '{
        chan_a: RST_CHAN_A, chan_b: RST_CHAN_B, chan_c: RST_CHAN_C,
        tx_a: RST_TX_A, user: {8{RST_USER}}, tx_b: RST_TX_B,
        sec_b: RST_SEC_B, run: RST_RUN, active_code: 4'h0,
        learn_sync: 2'h0, harv_sync: 2'h0, harv_prev: 1'b0,
        rdata: 8'h00, tel_valid: 1'b0, tel_supp: 1'b0,
        tel_status: 8'h00, pair_req: 1'b0};

endpackage : cfg_regs_pkg

// [cfg_fields_if.sv]
// Interface carrying raw register fields to the decoder and decoded
// settings back. Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface cfg_fields_if;
    logic       clk;
    logic [7:0] tx_b;
    logic [7:0] sec_b;
    logic [3:0] active_code;
    logic [1:0] step_mode;
    logic [1:0] wrap_mode;
    logic [1:0] key_choice;
    logic       pairing_allowed;
    logic [3:0] next_code;
    logic [4:0] channel_number;

    modport bank (output clk, tx_b, sec_b, active_code,
                  input step_mode, wrap_mode, key_choice,
                  pairing_allowed, next_code, channel_number);
    modport decode (input clk, tx_b, sec_b, active_code,
                    output step_mode, wrap_mode, key_choice,
                    pairing_allowed, next_code, channel_number);
endinterface : cfg_fields_if

// [config_decode.sv]
// Decoder of the second-protocol transmit and security fields.
// Assumes register values arrive from the bank through cfg_fields_if.
`timescale 1ns/1ns
module config_decode (
    // Fields and decoded settings
    cfg_fields_if.decode f
);
    import cfg_regs_pkg::*;

    // ------------------------------------------------------------------
    // Next primary channel code above the current one, wrapping around
    // ------------------------------------------------------------------
    function automatic logic [3:0] next_primary(input logic [3:0] code);
        if (code < PRIM_1)
            next_primary = PRIM_1;
        else if (code < PRIM_2)
            next_primary = PRIM_2;
        else if (code < PRIM_3)
            next_primary = PRIM_3;
        else
            next_primary = PRIM_0;
    endfunction : next_primary

    // ------------------------------------------------------------------
    // Field decode; reserved codes fall back to the field default
    // ------------------------------------------------------------------
    always_comb begin
        f.step_mode = (f.tx_b[5:4] == 2'h3) ? STEP_ALL : f.tx_b[5:4];
        f.wrap_mode = (f.sec_b[1:0] == 2'h3) ? WRAP_DEFAULT
                                             : f.sec_b[1:0];
        f.key_choice = (f.sec_b[3:2] == KEY_SECOND) ? KEY_SECOND
                                                    : KEY_FIRST;
        // Bit 5 of the security register is never looked at
        f.pairing_allowed = ~f.sec_b[PAIR_DISABLE_BIT];
        f.channel_number = CHANNEL_BASE + {1'b0, f.active_code};
        unique case (f.step_mode)
            STEP_PRIMARY: f.next_code = next_primary(f.active_code);
            STEP_ALL:     f.next_code = f.active_code + 4'h1;
            default:      f.next_code = f.active_code;
        endcase
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // The reserved wrap code must behave as the default wrap
    a_reserved_wrap_default: assert property (
        @(posedge f.clk)
        f.sec_b[1:0] == 2'h3 |-> f.wrap_mode == WRAP_DEFAULT)
        else $error("reserved wrap code not defaulted");

endmodule : config_decode

// [radio_telegram_config_registers.sv]
// Configuration bank of a self-powered pushbutton radio transmitter:
// custom channels, user status codes, second-protocol channel and security.
// Assumes an 8-bit register access port driven on ref_clk, status events
// from same-clock logic, and learn button and harvester levels from pins.
//
// Notes on behaviour
// - Custom channels are 7 bits, bit 7 reserved, resets 0x25, 0x26, 0x27.
// - Custom sequences on make the custom channels replace the standard ones.
// - Custom encoding sends the user status register picked by the index.
// - Index 0 (inputs open, harvester pressed) sends user status zero.
// - A selected user status of 0xFF suppresses the data telegram.
// - Channel code 0..15 in bits 3:0 maps to channel 11..26.
// - Bits 5:4 pick no, primary or full stepping from the configured channel.
// - Transmit register B resets to 0x20: channel 11, full stepping.
// - Security bits 1:0 pick the key wrap of pairing telegrams.
// - The key field picks the first key on 00 and the second key on 01.
// - Security bit 4 low lets a learn action send pairing; high blocks it.
// - Transmit register A bit 6 picks default or custom status encoding.
`timescale 1ns/1ns
module radio_telegram_config_registers (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Register access port
    input  wire logic       cfg_valid,
    input  wire logic       cfg_write,
    input  wire logic [4:0] cfg_index,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    // Status events from the input sensing logic
    input  wire logic       status_event,
    input  wire logic [2:0] status_index,
    // Pins
    input  wire logic       learn_button,
    input  wire logic       harvester_press,
    // Telegram requests
    output logic            telegram_valid,
    output logic            telegram_suppressed,
    output logic      [7:0] telegram_status,
    output logic            pairing_request,
    // Radio settings
    output logic            custom_sequence_active,
    output logic      [6:0] custom_channel_number_a,
    output logic      [6:0] custom_channel_number_b,
    output logic      [6:0] custom_channel_number_c,
    output logic      [4:0] proto_b_channel_number,
    output logic      [1:0] button_channel_stepping,
    output logic      [1:0] pairing_key_wrap_mode,
    output logic      [1:0] auth_key_choice
);
    import cfg_regs_pkg::*;

    bank_state_t st;
    bank_state_t next_st;
    cfg_fields_if fields ();
    logic         wr;
    logic         pair_event;
    logic [7:0]   picked;

    // ------------------------------------------------------------------
    // Field decoder
    // ------------------------------------------------------------------
    config_decode u_decode (
        .f (fields.decode)
    );

    // Clock and raw fields out to the decoder
    assign fields.clk         = ref_clk;
    assign fields.tx_b        = st.tx_b;
    assign fields.sec_b       = st.sec_b;
    assign fields.active_code = st.active_code;

    // ------------------------------------------------------------------
    // Read mux; unmapped indices read zero
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_reg(input bank_state_t s,
                                            input logic [4:0] idx);
        if (idx >= IDX_USER_BASE && idx <= IDX_USER_LAST)
            read_reg = s.user[3'(idx - IDX_USER_BASE)];
        else begin
            unique case (idx)
                IDX_CHAN_A: read_reg = s.chan_a;
                IDX_CHAN_B: read_reg = s.chan_b;
                IDX_CHAN_C: read_reg = s.chan_c;
                IDX_TX_A:   read_reg = s.tx_a;
                IDX_TX_B:   read_reg = s.tx_b;
                IDX_SEC_B:  read_reg = s.sec_b;
                IDX_RUN:    read_reg = s.run;
                IDX_ACTIVE: read_reg = {4'h0, s.active_code};
                default:    read_reg = 8'h00;
            endcase
        end
    endfunction : read_reg

    assign wr         = cfg_valid & cfg_write;
    // Harvester rising edge while the learn button is held
    assign pair_event = st.harv_sync[1] & ~st.harv_prev & st.learn_sync[1];
    assign picked     = st.user[status_index];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Pins pass two flops before anything reads them
        next_st.learn_sync = {st.learn_sync[0], learn_button};
        next_st.harv_sync  = {st.harv_sync[0], harvester_press};
        next_st.harv_prev  = st.harv_sync[1];
        next_st.rdata      = (cfg_valid & ~cfg_write)
                           ? read_reg(st, cfg_index) : st.rdata;
        // Channel stepping on a learn action; a transmit register B write wins since
        // stepping must restart from the freshly configured channel
        if (pair_event)
            next_st.active_code = fields.next_code;
        if (wr) begin
            if (cfg_index >= IDX_USER_BASE && cfg_index <= IDX_USER_LAST)
                next_st.user[3'(cfg_index - IDX_USER_BASE)] = cfg_wdata;
            unique case (cfg_index)
                IDX_CHAN_A: next_st.chan_a = cfg_wdata & CHAN_MASK;
                IDX_CHAN_B: next_st.chan_b = cfg_wdata & CHAN_MASK;
                IDX_CHAN_C: next_st.chan_c = cfg_wdata & CHAN_MASK;
                IDX_TX_A:   next_st.tx_a   = cfg_wdata;
                IDX_TX_B: begin
                    next_st.tx_b        = cfg_wdata;
                    next_st.active_code = cfg_wdata[3:0];
                end
                IDX_SEC_B:  next_st.sec_b  = cfg_wdata;
                IDX_RUN:    next_st.run    = cfg_wdata;
                default: ;
            endcase
        end
        // Status telegram: custom code, suppression, or default index
        next_st.tel_valid  = 1'b0;
        next_st.tel_supp   = 1'b0;
        if (status_event) begin
            if (st.tx_a[CUSTOM_ENCODING_BIT]) begin
                next_st.tel_supp   = (picked == SUPPRESS_CODE);
                next_st.tel_valid  = (picked != SUPPRESS_CODE);
                next_st.tel_status = picked;
            end else begin
                next_st.tel_valid  = 1'b1;
                next_st.tel_status = {5'h00, status_index};
            end
        end
        next_st.pair_req = pair_event & fields.pairing_allowed;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            st <= RESET_STATE;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_rdata               = st.rdata;
    assign telegram_valid          = st.tel_valid;
    assign telegram_suppressed     = st.tel_supp;
    assign telegram_status         = st.tel_status;
    assign pairing_request         = st.pair_req;
    assign custom_sequence_active  = st.run[CUSTOM_SEQ_BIT];
    assign custom_channel_number_a = st.chan_a[6:0];
    assign custom_channel_number_b = st.chan_b[6:0];
    assign custom_channel_number_c = st.chan_c[6:0];
    assign proto_b_channel_number  = fields.channel_number;
    assign button_channel_stepping = fields.step_mode;
    assign pairing_key_wrap_mode   = fields.wrap_mode;
    assign auth_key_choice         = fields.key_choice;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_chan_write_lands: assert property (
        wr && cfg_index == IDX_CHAN_B |=>
        custom_channel_number_b == $past(cfg_wdata[6:0]))
        else $error("custom channel write not stored");
    a_custom_status_sent: assert property (
        status_event && st.tx_a[CUSTOM_ENCODING_BIT] &&
        picked != SUPPRESS_CODE |=>
        telegram_valid && telegram_status == $past(picked))
        else $error("custom status value not sent");
    a_index_zero_pick: assert property (
        status_event && status_index == 3'h0 &&
        st.tx_a[CUSTOM_ENCODING_BIT] && st.user[0] != SUPPRESS_CODE |=>
        telegram_status == $past(st.user[0]))
        else $error("index zero did not use user code zero");
    a_suppress_code: assert property (
        status_event && st.tx_a[CUSTOM_ENCODING_BIT] &&
        picked == SUPPRESS_CODE |=> telegram_suppressed && !telegram_valid)
        else $error("suppress code still sent a telegram");
    a_default_encoding: assert property (
        status_event && !st.tx_a[CUSTOM_ENCODING_BIT] |=>
        telegram_valid && telegram_status[2:0] == $past(status_index))
        else $error("default encoding wrong");
    a_channel_map: assert property (
        proto_b_channel_number == 5'(CHANNEL_BASE + st.active_code))
        else $error("channel mapping wrong");
    a_no_step_hold: assert property (
        fields.step_mode == STEP_NONE && !wr |=> $stable(st.active_code))
        else $error("channel stepped with stepping off");
    a_all_step_inc: assert property (
        pair_event && fields.step_mode == STEP_ALL && !wr |=>
        st.active_code == 4'($past(st.active_code) + 4'h1))
        else $error("full stepping did not advance");
    a_pairing_block: assert property (
        st.sec_b[PAIR_DISABLE_BIT] |=> !pairing_request)
        else $error("pairing sent while disabled");
    a_pairing_fire: assert property (
        pair_event && !st.sec_b[PAIR_DISABLE_BIT] |=> pairing_request)
        else $error("pairing request missing");
    a_reserved_defaults: assert property (
        st.sec_b[3:2] != KEY_SECOND |-> auth_key_choice == KEY_FIRST)
        else $error("reserved key code not defaulted");

    c_suppressed_event: cover property (status_event ##1 telegram_suppressed);
    c_pairing_sent:     cover property (pairing_request);
    c_primary_wrap:     cover property (pair_event &&
        fields.step_mode == STEP_PRIMARY && st.active_code == PRIM_3);

endmodule : radio_telegram_config_registers

// [radio_far_side.sv]
// Far-side model: the pushbutton pins and a receiver that counts pulses.
// Assumes the bank runs on ref_clk and each request pulse lasts one cycle.
`timescale 1ns/1ns
module radio_far_side (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Telegram requests from the bank
    input  wire logic telegram_valid,
    input  wire logic telegram_suppressed,
    input  wire logic pairing_request,
    // Pins towards the bank
    output logic      learn_button,
    output logic      harvester_press
);
    int sent_count;
    int dropped_count;
    int pairing_count;

    // ------------------------------------------------------------------
    // Receiver side
    // ------------------------------------------------------------------
    // Each high cycle is counted, so a pulse held two cycles shows up twice
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sent_count    <= 0;
            dropped_count <= 0;
            pairing_count <= 0;
        end else begin
            sent_count    <= sent_count + int'(telegram_valid);
            dropped_count <= dropped_count + int'(telegram_suppressed);
            pairing_count <= pairing_count + int'(pairing_request);
        end
    end

    // ------------------------------------------------------------------
    // Button side
    // ------------------------------------------------------------------
    // Pins rest released
    initial begin
        learn_button    = 1'b0;
        harvester_press = 1'b0;
    end

    // Learn settles four cycles before the harvester, beyond the sync delay
    task automatic press(input bit with_learn);
        @(posedge ref_clk) learn_button <= with_learn;
        repeat (4) @(posedge ref_clk);
        harvester_press <= 1'b1;
        repeat (8) @(posedge ref_clk);
        harvester_press <= 1'b0;
        learn_button    <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : press
endmodule : radio_far_side

// [radio_telegram_config_registers_bench.sv]
// Self-checking bench of the radio configuration bank.
// Assumes the bank's register port timing and the far-side model's counters.
`timescale 1ns/1ns
module radio_telegram_config_registers_bench;
    import cfg_regs_pkg::*;
    logic       ref_clk, rst_n, cfg_valid, cfg_write, status_event;
    logic [4:0] cfg_index, proto_b_channel_number;
    logic [7:0] cfg_wdata, cfg_rdata, telegram_status;
    logic [2:0] status_index;
    logic       learn_button, harvester_press, pairing_request;
    logic       telegram_valid, telegram_suppressed, custom_sequence_active;
    logic [6:0] custom_channel_number_a, custom_channel_number_b;
    logic [6:0] custom_channel_number_c;
    logic [1:0] button_channel_stepping, pairing_key_wrap_mode;
    logic [1:0] auth_key_choice;
    int         miscompares, compares;
    logic [4:0] idx_tab [9] = '{5'h00, 5'h01, 5'h02, 5'h0C, 5'h0D,
                                5'h03, 5'h04, 5'h0F, 5'h1F};
    logic [7:0] rst_tab [9] = '{8'h25, 8'h26, 8'h27, 8'h20, 8'h20,
                                8'h00, 8'h00, 8'h00, 8'h00};

    radio_telegram_config_registers u_radio_telegram_config_registers (
        .ref_clk(ref_clk), .rst_n(rst_n), .cfg_valid(cfg_valid),
        .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .status_event(status_event),
        .status_index(status_index), .learn_button(learn_button),
        .harvester_press(harvester_press), .telegram_valid(telegram_valid),
        .telegram_suppressed(telegram_suppressed),
        .telegram_status(telegram_status), .pairing_request(pairing_request),
        .custom_sequence_active(custom_sequence_active),
        .custom_channel_number_a(custom_channel_number_a),
        .custom_channel_number_b(custom_channel_number_b),
        .custom_channel_number_c(custom_channel_number_c),
        .proto_b_channel_number(proto_b_channel_number),
        .button_channel_stepping(button_channel_stepping),
        .pairing_key_wrap_mode(pairing_key_wrap_mode),
        .auth_key_choice(auth_key_choice));

    radio_far_side u_radio_far_side (
        .ref_clk(ref_clk), .rst_n(rst_n), .telegram_valid(telegram_valid),
        .telegram_suppressed(telegram_suppressed),
        .pairing_request(pairing_request), .learn_button(learn_button),
        .harvester_press(harvester_press));

    // ------------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------------
    // 25 MHz reference clock
    always #20 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // One access per call; ends just after the edge one cycle after the edge that loads read data
    task automatic access(input logic wr, input logic [4:0] idx,
                          input logic [7:0] data);
        @(posedge ref_clk);
        cfg_valid <= 1'b1;
        cfg_write <= wr;
        cfg_index <= idx;
        cfg_wdata <= data;
        @(posedge ref_clk);
        cfg_valid <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : access

    task automatic rd_check(input logic [4:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00);
        check("read data", cfg_rdata, exp);
    endtask : rd_check

    // Status event, then count what the receiver got in a short window
    task automatic fire(input logic [2:0] idx, input logic [7:0] exp,
                        input bit drop);
        int sent0;
        int drop0;
        sent0 = u_radio_far_side.sent_count;
        drop0 = u_radio_far_side.dropped_count;
        @(posedge ref_clk);
        status_event <= 1'b1;
        status_index <= idx;
        @(posedge ref_clk);
        status_event <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("sent", 8'(u_radio_far_side.sent_count - sent0), {7'h0, !drop});
        check("dropped", 8'(u_radio_far_side.dropped_count - drop0),
              {7'h0, drop});
        if (!drop) check("status", telegram_status, exp);
    endtask : fire

    // Button action; the active channel code is read back afterwards
    task automatic learn(input bit with_learn, input logic [7:0] code,
                         input int pairs);
        int p0;
        p0 = u_radio_far_side.pairing_count;
        u_radio_far_side.press(with_learn);
        check("pairing", 8'(u_radio_far_side.pairing_count - p0), 8'(pairs));
        rd_check(IDX_ACTIVE, code);
    endtask : learn

    // Hang guard, far above the length of the sequence below
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {cfg_valid, cfg_write, status_event} = 3'h0;
        cfg_index = 5'h00;
        cfg_wdata = 8'h00;
        status_index = 3'h0;
        miscompares = 0;
        compares = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd_check(idx_tab[i], rst_tab[i]);
        check("channel", {3'h0, proto_b_channel_number}, 8'h0B);
        check("stepping", {6'h0, button_channel_stepping}, 8'h02);
        // Bit 7 of the channel registers never sticks
        for (int i = 0; i < 3; i++) begin
            access(1'b1, 5'(i), 8'hC0 + 8'(i));
            rd_check(5'(i), 8'h40 + 8'(i));
        end
        check("custom a", {1'b0, custom_channel_number_a}, 8'h40);
        check("custom b", {1'b0, custom_channel_number_b}, 8'h41);
        check("custom c", {1'b0, custom_channel_number_c}, 8'h42);
        access(1'b1, IDX_ACTIVE, 8'h0A);
        rd_check(IDX_ACTIVE, 8'h00);
        access(1'b1, IDX_RUN, 8'h01);
        check("sequence", {7'h0, custom_sequence_active}, 8'h01);
        fire(3'h5, 8'h05, 1'b0);
        access(1'b1, IDX_TX_A, 8'h40);
        for (int i = 0; i < 8; i++) access(1'b1, 5'(4 + i), 8'h10 + 8'(i));
        for (int i = 0; i < 8; i++)
            fire(3'(i), 8'h10 + 8'(i), 1'b0);
        access(1'b1, 5'h07, 8'hFF);
        fire(3'h3, 8'h00, 1'b1);
        for (int i = 0; i < 16; i++) begin
            access(1'b1, IDX_TX_B, 8'(i));
            check("channel", {3'h0, proto_b_channel_number}, 8'(11 + i));
        end
        // Reserved codes fall back to the field default
        for (int i = 0; i < 4; i++) begin
            access(1'b1, IDX_TX_B, {2'h0, 2'(i), 4'h0});
            check("stepping", {6'h0, button_channel_stepping},
                  (i == 3) ? 8'h02 : 8'(i));
            access(1'b1, IDX_SEC_B, {6'h0, 2'(i)});
            check("wrap", {6'h0, pairing_key_wrap_mode},
                  (i == 3) ? 8'h00 : 8'(i));
            access(1'b1, IDX_SEC_B, {4'h0, 2'(i), 2'h0});
            check("key", {6'h0, auth_key_choice},
                  (i == 1) ? 8'h01 : 8'h00);
        end
        rd_check(IDX_SEC_B, 8'h0C);
        access(1'b1, IDX_SEC_B, 8'h20);
        access(1'b1, IDX_TX_B, 8'h23);
        learn(1'b1, 8'h04, 1);
        learn(1'b0, 8'h04, 0);
        access(1'b1, IDX_SEC_B, 8'h10);
        learn(1'b1, 8'h05, 0);
        access(1'b1, IDX_TX_B, 8'h07);
        learn(1'b1, 8'h07, 0);
        access(1'b1, IDX_TX_B, 8'h14);
        learn(1'b1, 8'h09, 0);
        access(1'b1, IDX_TX_B, 8'h1E);
        learn(1'b1, 8'h00, 0);
        stop_test();
    end
endmodule : radio_telegram_config_registers_bench
